// >>> rtl/mctl2_top.sv
// Purpose: Sensor control two register and reset-cycle sequencing
// Assumes: Single clock; register port from the serial interface logic
// Notes:   Summary of operation below
// Summary of operation
// - Auto enable set: sensor reset cycle runs before every acquisition.
// - Auto enable is write-only; reads always return zero.
// - Raw select zero: outputs corrected by user offset values.
// - Raw select one: outputs presented without user offset correction.
// - Factory calibration is always applied, whatever raw select says.
// - Writing one to the one-shot bit starts one reset cycle.
// - One-shot bit reads one while a reset cycle is busy.
// - One-shot bit clears itself when the reset cycle completes.
// - After reset all three control bits hold zero.
`timescale 1ns/1ps
`include "mctl2_map.svh"
module mctl2_top #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst,
  // Register port
  input  wire logic                  i_reg_wr,
  input  wire logic [7:0]            i_reg_addr,
  input  wire logic [7:0]            i_reg_wdata,
  output logic      [7:0]            o_reg_rdata,
  // Measurement sequencer
  input  wire logic                  i_acq_req,
  output logic                       o_acq_go,
  output logic                       o_sensor_reset,
  input  wire logic                  i_reset_done,
  output logic                       o_reset_busy,
  // Output data path
  input  wire logic                  i_smp_valid,
  input  wire mctl2_pkg::mctl2_sample_t i_smp_cal,
  input  wire mctl2_pkg::mctl2_sample_t i_user_offset,
  output logic                       o_out_valid,
  output mctl2_pkg::mctl2_sample_t   o_out_data
);
  import mctl2_pkg::*;

  localparam logic [7:0] RST_CYC = 8'(`MCTL2_RST_CYCLES);

  function automatic logic hit(input logic [7:0] a);
    hit = (a == `MCTL2_ADDR_CTRL2);
  endfunction : hit

  logic         auto_reg, auto_next;
  logic         raw_reg, raw_next;
  logic         pend_reg, pend_next;
  logic         acq_reg, acq_next;
  logic         go_reg, go_next;
  logic [7:0]   cnt_reg, cnt_next;
  logic [7:0]   rd_reg, rd_next;
  mctl2_state_t st_reg, st_next;
  logic         wr_hit;
  logic         busy;

  assign wr_hit = i_reg_wr && hit(i_reg_addr);
  assign busy   = pend_reg || (st_reg != MCTL2_IDLE);

  // Control bits; bits 6,3..0 are not stored
  always_comb begin
    auto_next = auto_reg;
    raw_next  = raw_reg;
    if (wr_hit) begin
      auto_next = i_reg_wdata[`MCTL2_BIT_AUTO_EN];
      raw_next  = i_reg_wdata[`MCTL2_BIT_RAW];
    end
  end

  // Sequencer: a manual request or auto-before-acquire runs one cycle.
  // Acquisition is held until the reset cycle ends when auto is on.
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    pend_next = pend_reg;
    acq_next  = acq_reg;
    go_next   = 1'b0;
    if (wr_hit && i_reg_wdata[`MCTL2_BIT_ONESHOT]) begin
      pend_next = 1'b1;
    end
    if (i_acq_req) begin
      if (auto_reg) begin
        acq_next  = 1'b1;
        pend_next = 1'b1;
      end else begin
        go_next = 1'b1;
      end
    end
    unique case (st_reg)
      MCTL2_IDLE: begin
        if (pend_reg) begin
          st_next   = MCTL2_PULSE;
          cnt_next  = RST_CYC - 8'h01;
        end
      end
      MCTL2_PULSE: begin
        if (cnt_reg == 8'h00) begin
          st_next = MCTL2_WAIT;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      MCTL2_WAIT: begin
        if (i_reset_done) begin
          st_next   = MCTL2_IDLE;
          pend_next = pend_next && !(pend_reg && !wr_hit && !i_acq_req);
          if (acq_reg) begin
            go_next  = 1'b1;
            acq_next = 1'b0;
          end
        end
      end
      default: st_next = MCTL2_IDLE;
    endcase
    if (st_reg == MCTL2_IDLE && pend_reg) begin
      pend_next = (wr_hit && i_reg_wdata[`MCTL2_BIT_ONESHOT]) ||
                  (i_acq_req && auto_reg);
    end
  end

  // Read mux; auto enable and unused bits read zero
  always_comb begin
    rd_next = 8'h00;
    if (hit(i_reg_addr)) begin
      rd_next[`MCTL2_BIT_RAW]     = raw_reg;
      rd_next[`MCTL2_BIT_ONESHOT] = busy;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      auto_reg <= 1'b0;
      raw_reg  <= 1'b0;
      pend_reg <= 1'b0;
      acq_reg  <= 1'b0;
      go_reg   <= 1'b0;
      cnt_reg  <= 8'h00;
      rd_reg   <= `MCTL2_RESET_VALUE;
      st_reg   <= MCTL2_IDLE;
    end else begin
      auto_reg <= auto_next;
      raw_reg  <= raw_next;
      pend_reg <= pend_next;
      acq_reg  <= acq_next;
      go_reg   <= go_next;
      cnt_reg  <= cnt_next;
      rd_reg   <= rd_next;
      st_reg   <= st_next;
    end
  end

  assign o_reg_rdata    = rd_reg;
  assign o_acq_go       = go_reg;
  assign o_sensor_reset = (st_reg == MCTL2_PULSE);
  assign o_reset_busy   = busy;

  // Calibrated input; only the user offset depends on raw select
  mctl2_offset #(.W(W)) u_offset (
    .i_mclk   (i_mclk),
    .i_rst    (i_rst),
    .i_valid  (i_smp_valid),
    .i_sample (i_smp_cal),
    .i_offset (i_user_offset),
    .i_raw    (raw_reg),
    .o_valid  (o_out_valid),
    .o_data   (o_out_data)
  );

  // Reset cancels any open attempt; only the release check looks past it
  chk_auto_reads_zero: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    o_reg_rdata[`MCTL2_BIT_AUTO_EN] == 1'b0)
    else $error("auto enable read back non-zero");
  chk_unused_zero: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (o_reg_rdata & 8'h4F) == 8'h00)
    else $error("unused bit read non-zero");
  chk_oneshot_starts: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (wr_hit && i_reg_wdata[`MCTL2_BIT_ONESHOT]) |=> busy ##[0:2]
    o_sensor_reset)
    else $error("one-shot write did not start a reset cycle");
  chk_busy_read: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    hit(i_reg_addr) |=> o_reg_rdata[`MCTL2_BIT_ONESHOT] == $past(busy))
    else $error("one-shot read does not match busy");
  chk_self_clear: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (st_reg == MCTL2_WAIT && i_reset_done && !pend_reg && !wr_hit
     && !i_acq_req) |=> !busy)
    else $error("one-shot did not clear after cycle");
  chk_auto_before_acq: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (i_acq_req && auto_reg && !busy) |=> !o_acq_go ##[1:2] o_sensor_reset)
    else $error("acquisition not preceded by reset cycle");
  chk_no_auto_reset: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (i_acq_req && !auto_reg) |=> o_acq_go)
    else $error("acquisition held while auto is off");
  // A held acquisition is released only by the analog done pulse
  chk_go_after_done: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (st_reg == MCTL2_WAIT && i_reset_done && acq_reg) |=> o_acq_go)
    else $error("held acquisition not released after reset cycle");
  // Pulse phase starts with a full count and ends when it runs out
  chk_pulse_start: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    $rose(o_sensor_reset) |-> cnt_reg == RST_CYC - 8'h01)
    else $error("reset pulse started with a short count");
  chk_pulse_end: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (o_sensor_reset && cnt_reg == 8'h00) |=> !o_sensor_reset)
    else $error("reset pulse ran past its count");
  // Looked at on the first edge after release, so no disable here
  chk_reset_clean: assert property (
    @(posedge i_mclk)
    $fell(i_rst) |-> (o_reg_rdata == 8'h00 && !o_reset_busy && !o_acq_go
     && !o_sensor_reset && !auto_reg && !raw_reg && !pend_reg))
    else $error("control state not cleared by reset");
  chk_raw_path: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (i_smp_valid && raw_reg) |=> o_out_data == $past(i_smp_cal))
    else $error("raw mode applied correction");
  chk_corr_path: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (i_smp_valid && !raw_reg) |=>
    o_out_data == W'($past(i_smp_cal) - $past(i_user_offset)))
    else $error("normal mode missing correction");
  cov_oneshot: cover property (@(posedge i_mclk)
    st_reg == MCTL2_WAIT && i_reset_done && !acq_reg);
  cov_auto_acq: cover property (@(posedge i_mclk) acq_reg && o_acq_go);
  cov_raw: cover property (@(posedge i_mclk) i_smp_valid && raw_reg);
  cov_reset_release: cover property (@(posedge i_mclk) $fell(i_rst));
endmodule : mctl2_top

// >>> rtl/mctl2_map.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 8-bit register port, 40 MHz clock
// Notes:   Definitions only
`ifndef MCTL2_MAP_SVH
`define MCTL2_MAP_SVH
`define MCTL2_ADDR_CTRL2     8'h11
`define MCTL2_BIT_AUTO_EN    7
`define MCTL2_BIT_RAW        5
`define MCTL2_BIT_ONESHOT    4
`define MCTL2_RESET_VALUE    8'h00
`define MCTL2_CLK_MHZ        40
`define MCTL2_RST_CYCLE_US   1
`define MCTL2_RST_CYCLES     (`MCTL2_RST_CYCLE_US * `MCTL2_CLK_MHZ)
`endif

// >>> rtl/mctl2_pkg.sv
// Purpose: Types for the sensor control two block
// Assumes: Used with mctl2_map.svh
// Notes:   One-hot reset sequencer states
package mctl2_pkg;
  typedef enum logic [2:0] {
    MCTL2_IDLE  = 3'b001,
    MCTL2_PULSE = 3'b010,
    MCTL2_WAIT  = 3'b100
  } mctl2_state_t;
  typedef logic [15:0] mctl2_sample_t;
endpackage : mctl2_pkg

// >>> rtl/mctl2_offset.sv
// Purpose: Output data path, user offset correction per axis
// Assumes: Samples already factory calibrated upstream
// Notes:   Data out is registered
`timescale 1ns/1ps
module mctl2_offset #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  // Sample in
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_sample,
  input  wire logic [W-1:0] i_offset,
  input  wire logic         i_raw,
  // Sample out
  output logic              o_valid,
  output logic      [W-1:0] o_data
);
  logic [W-1:0] data_reg;
  logic [W-1:0] data_next;
  logic         valid_reg;

  always_comb begin
    data_next = data_reg;
    if (i_valid) begin
      data_next = i_raw ? i_sample : W'(i_sample - i_offset);
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      data_reg  <= '0;
      valid_reg <= 1'b0;
    end else begin
      data_reg  <= data_next;
      valid_reg <= i_valid;
    end
  end

  assign o_data  = data_reg;
  assign o_valid = valid_reg;
endmodule : mctl2_offset

// >>> dv/mctl2_seq_model.sv
// Purpose: Analog reset responder on the sequencer side
// Assumes: Pulse phase marked by the sensor reset output
// Notes:   Done follows the pulse phase promptly or slowly
`timescale 1ns/1ps
module mctl2_seq_model (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst,
  // Control
  input  wire logic i_slow,
  input  wire logic i_sensor_reset,
  // Answer
  output logic      o_reset_done
);
  int   wait_cnt;
  logic pulse_prev;
  // Slow mode stands in for a sluggish analog settle
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wait_cnt <= 0;
      pulse_prev <= 1'b0;
      o_reset_done <= 1'b0;
    end else begin
      pulse_prev <= i_sensor_reset;
      o_reset_done <= (wait_cnt == 1);
      if (pulse_prev && !i_sensor_reset) begin
        wait_cnt <= i_slow ? 20 : 1;
      end else if (wait_cnt != 0) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule : mctl2_seq_model

// >>> dv/test_mctl2_top.sv
// Purpose: Self-checking bench for the sensor control two block
// Assumes: One byte per write strobe, 40 MHz clock
// Notes:   Sensor reset pulse cycles and acquisition go pulses counted on every rising clock edge
`timescale 1ns/1ps
`include "mctl2_map.svh"
module test_mctl2_top;
  import mctl2_pkg::*;
  localparam logic [7:0]  A  = `MCTL2_ADDR_CTRL2;
  localparam logic [15:0] NR = 16'(`MCTL2_RST_CYCLES);
  logic          i_mclk = 1'b0;
  logic          i_rst = 1'b1;
  logic          i_reg_wr = 1'b0;
  logic [7:0]    i_reg_addr = 8'h00;
  logic [7:0]    i_reg_wdata = 8'h00;
  logic          i_acq_req = 1'b0;
  logic          i_smp_valid = 1'b0;
  mctl2_sample_t i_smp_cal = 16'h0000;
  mctl2_sample_t i_user_offset = 16'h0000;
  logic          slow = 1'b0;
  logic [7:0]    o_reg_rdata;
  logic          o_acq_go, o_sensor_reset, o_reset_busy, o_out_valid, done;
  mctl2_sample_t o_out_data;
  logic [15:0]   nrst = 16'h0000, ngo = 16'h0000, rst_at_go = 16'h0000;
  int            n_mismatch = 0;
  int            checks = 0;
  always #12.5 i_mclk = ~i_mclk;
  mctl2_top dut (.i_mclk, .i_rst, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
    .o_reg_rdata, .i_acq_req, .o_acq_go, .o_sensor_reset,
    .i_reset_done(done), .o_reset_busy, .i_smp_valid, .i_smp_cal,
    .i_user_offset, .o_out_valid, .o_out_data);
  mctl2_seq_model u_model (.i_mclk, .i_rst, .i_slow(slow),
    .i_sensor_reset(o_sensor_reset), .o_reset_done(done));
  always @(posedge i_mclk) begin
    if (o_sensor_reset === 1'b1) nrst++;
    if (o_acq_go === 1'b1) begin
      ngo++;
      rst_at_go = nrst;
    end
  end
  task automatic tick;
    @(posedge i_mclk);
    #1;
  endtask : tick
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    tick();
    i_reg_wr = 1'b0;
    i_reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_reg_addr = a;
    tick();
    chk({8'h00, o_reg_rdata}, {8'h00, e});
  endtask : rd
  task automatic smp(input mctl2_sample_t s, o, e);
    i_smp_valid = 1'b1;
    i_smp_cal = s;
    i_user_offset = o;
    tick();
    i_smp_valid = 1'b0;
    i_smp_cal = ~s;
    chk(16'(o_out_valid), 16'h0001);
    chk(o_out_data, e);
  endtask : smp
  task automatic acq;
    nrst = 16'h0000;
    ngo = 16'h0000;
    i_acq_req = 1'b1;
    tick();
    i_acq_req = 1'b0;
  endtask : acq
  task automatic report_and_stop;
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #(25 * 20000);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge i_mclk);
    #1;
    i_rst = 1'b0;
    chk(16'(o_reset_busy), 16'h0000);
    rd(A, 8'h00);
    smp(16'h1234, 16'h0034, 16'h1200);
    wr(A, 8'hEF);
    rd(A, 8'h20);
    smp(16'h1234, 16'h0034, 16'h1234);
    wr(8'h10, 8'h00);
    rd(8'h10, 8'h00);
    rd(A, 8'h20);
    wr(A, 8'h80);
    smp(16'h0000, 16'h0001, 16'hFFFF);
    for (int k = 0; k < 2; k++) begin
      slow = k[0];
      acq();
      rd(A, 8'h10);
      repeat (100) tick();
      chk(nrst, NR);
      chk(ngo, 16'h0001);
      chk(rst_at_go, NR);
      chk(16'(o_reset_busy), 16'h0000);
    end
    wr(A, 8'h00);
    acq();
    tick();
    chk(ngo, 16'h0001);
    repeat (100) tick();
    chk(nrst, 16'h0000);
    nrst = 16'h0000;
    ngo = 16'h0000;
    wr(A, 8'h10);
    rd(A, 8'h10);
    repeat (100) tick();
    chk(nrst, NR);
    chk(ngo, 16'h0000);
    rd(A, 8'h00);
    wr(A, 8'hB0);
    i_rst = 1'b1;
    tick();
    i_rst = 1'b0;
    rd(A, 8'h00);
    smp(16'h0100, 16'h0001, 16'h00FF);
    report_and_stop();
  end
endmodule : test_mctl2_top
